// File: hw/dpr_sram.sv
/*
 True dual-port synchronous 128K x 8 memory with per-port address counter
 and per-port flow-through or pipelined read stage.
 Assumes both masters are logic on clk_i and resolve their own collisions;
 data pins are split into input, output and active-low output enable.
*/
// Behaviour
// RULE1 - 128K x 8 array reachable from both ports
// RULE2 - Address, data, controls registered on clock edge
// RULE3 - Ports synchronous and independent of each other
// RULE4 - Selected only when low select low, high select high
// RULE5 - Masters may use selects for depth expansion
// RULE6 - Selected with R/W low writes, ignoring output enable
// RULE7 - Selected, R/W high, output enable low reads
// RULE8 - Output enable high floats data asynchronously
// RULE9 - Counter clear low forces address zero
// RULE10 - Load strobe low loads external address
// RULE11 - Counter advance high holds previous address
// RULE12 - Counter advance low increments held address
// RULE13 - Load strobe ignores chip selects
// RULE14 - Counter advances even when deselected
// RULE15 - Each port selects its own output stage
// RULE16 - Pipelined read data one cycle later
// RULE17 - Master keeps R/W high during address loads
// RULE18 - Same-address collisions with writes are undefined
`timescale 1ns/100ps
`default_nettype none

module dpr_sram
(
	input  wire logic                       clk_i,
	input  wire logic                       reset_n_i,
	input  wire logic [dpr_pkg::ADDR_W-1:0] left_addr_i,
	input  wire logic [dpr_pkg::DATA_W-1:0] left_data_i,
	output logic      [dpr_pkg::DATA_W-1:0] left_data_o,
	output logic                            left_data_oe_n_o,
	input  wire logic                       left_port_select_active_low_i,
	input  wire logic                       left_port_select_active_high_i,
	input  wire logic                       left_read_write_i,
	input  wire logic                       left_output_enable_n_i,
	input  wire logic                       left_address_load_strobe_n_i,
	input  wire logic                       left_counter_advance_n_i,
	input  wire logic                       left_counter_clear_n_i,
	input  wire logic                       left_output_stage_select_i,
	output logic                            left_standby_o,
	input  wire logic [dpr_pkg::ADDR_W-1:0] right_addr_i,
	input  wire logic [dpr_pkg::DATA_W-1:0] right_data_i,
	output logic      [dpr_pkg::DATA_W-1:0] right_data_o,
	output logic                            right_data_oe_n_o,
	input  wire logic                       right_port_select_active_low_i,
	input  wire logic                       right_port_select_active_high_i,
	input  wire logic                       right_read_write_i,
	input  wire logic                       right_output_enable_n_i,
	input  wire logic                       right_address_load_strobe_n_i,
	input  wire logic                       right_counter_advance_n_i,
	input  wire logic                       right_counter_clear_n_i,
	input  wire logic                       right_output_stage_select_i,
	output logic                            right_standby_o
);

	localparam int unsigned NP = dpr_pkg::NUM_PORTS;

	logic [dpr_pkg::DATA_W-1:0] mem [dpr_pkg::DEPTH]; // RULE1

	// Per-port views of the pins
	logic [dpr_pkg::ADDR_W-1:0] pin_addr    [NP];
	logic [dpr_pkg::DATA_W-1:0] pin_data    [NP];
	logic                       pin_sel_n   [NP];
	logic                       pin_sel_h   [NP];
	logic                       pin_rw      [NP];
	logic                       pin_oe_n    [NP];
	logic                       pin_ads_n   [NP];
	logic                       pin_adv_n   [NP];
	logic                       pin_clr_n   [NP];
	logic                       pin_mode    [NP];
	logic [dpr_pkg::DATA_W-1:0] out_data    [NP];
	logic                       out_oe_n    [NP];
	logic                       out_standby [NP];

	// Registered access of each port
	logic [dpr_pkg::ADDR_W-1:0] acc_addr  [NP];
	logic [dpr_pkg::DATA_W-1:0] acc_wdata [NP];
	logic                       acc_write [NP];
	logic                       acc_read  [NP];
	logic                       acc_sel   [NP];

	assign pin_addr[dpr_pkg::PORT_LEFT]   = left_addr_i;
	assign pin_data[dpr_pkg::PORT_LEFT]   = left_data_i;
	assign pin_sel_n[dpr_pkg::PORT_LEFT]  = left_port_select_active_low_i;
	assign pin_sel_h[dpr_pkg::PORT_LEFT]  = left_port_select_active_high_i;
	assign pin_rw[dpr_pkg::PORT_LEFT]     = left_read_write_i;
	assign pin_oe_n[dpr_pkg::PORT_LEFT]   = left_output_enable_n_i;
	assign pin_ads_n[dpr_pkg::PORT_LEFT]  = left_address_load_strobe_n_i;
	assign pin_adv_n[dpr_pkg::PORT_LEFT]  = left_counter_advance_n_i;
	assign pin_clr_n[dpr_pkg::PORT_LEFT]  = left_counter_clear_n_i;
	assign pin_mode[dpr_pkg::PORT_LEFT]   = left_output_stage_select_i;

	assign pin_addr[dpr_pkg::PORT_RIGHT]  = right_addr_i;
	assign pin_data[dpr_pkg::PORT_RIGHT]  = right_data_i;
	assign pin_sel_n[dpr_pkg::PORT_RIGHT] = right_port_select_active_low_i;
	assign pin_sel_h[dpr_pkg::PORT_RIGHT] = right_port_select_active_high_i;
	assign pin_rw[dpr_pkg::PORT_RIGHT]    = right_read_write_i;
	assign pin_oe_n[dpr_pkg::PORT_RIGHT]  = right_output_enable_n_i;
	assign pin_ads_n[dpr_pkg::PORT_RIGHT] = right_address_load_strobe_n_i;
	assign pin_adv_n[dpr_pkg::PORT_RIGHT] = right_counter_advance_n_i;
	assign pin_clr_n[dpr_pkg::PORT_RIGHT] = right_counter_clear_n_i;
	assign pin_mode[dpr_pkg::PORT_RIGHT]  = right_output_stage_select_i;

	assign left_data_o       = out_data[dpr_pkg::PORT_LEFT];
	assign left_data_oe_n_o  = out_oe_n[dpr_pkg::PORT_LEFT];
	assign left_standby_o    = out_standby[dpr_pkg::PORT_LEFT];
	assign right_data_o      = out_data[dpr_pkg::PORT_RIGHT];
	assign right_data_oe_n_o = out_oe_n[dpr_pkg::PORT_RIGHT];
	assign right_standby_o   = out_standby[dpr_pkg::PORT_RIGHT];

	// Array write; a same-cycle write clash on one word lets the right port
	// land last, which the masters must not rely on
	always_ff @(posedge clk_i)
	begin
		if (acc_write[dpr_pkg::PORT_LEFT])
		begin
			mem[acc_addr[dpr_pkg::PORT_LEFT]] <= acc_wdata[dpr_pkg::PORT_LEFT]; // RULE6
		end
		if (acc_write[dpr_pkg::PORT_RIGHT])
		begin
			mem[acc_addr[dpr_pkg::PORT_RIGHT]] <= acc_wdata[dpr_pkg::PORT_RIGHT]; // RULE6 RULE18
		end
	end

	for (genvar p = 0; p < NP; p++)
	begin : g_port
		logic [dpr_pkg::DATA_W-1:0] ft_data_r;
		logic [dpr_pkg::DATA_W-1:0] ft_data_nxt;
		logic                       ft_valid_r;
		logic                       ft_valid_nxt;
		logic [dpr_pkg::DATA_W-1:0] pipe_data_r;
		logic [dpr_pkg::DATA_W-1:0] pipe_data_nxt;
		logic                       pipe_valid_r;
		logic                       pipe_valid_nxt;
		logic                       stage_valid;

		dpr_port_ctl u_ctl
		(
			.clk_i                     (clk_i),
			.reset_n_i                 (reset_n_i),
			.addr_i                    (pin_addr[p]),
			.data_i                    (pin_data[p]),
			.port_select_active_low_i  (pin_sel_n[p]),
			.port_select_active_high_i (pin_sel_h[p]),
			.read_write_i              (pin_rw[p]),
			.address_load_strobe_n_i   (pin_ads_n[p]),
			.counter_advance_n_i       (pin_adv_n[p]),
			.counter_clear_n_i         (pin_clr_n[p]),
			.access_addr_o             (acc_addr[p]),
			.wdata_o                   (acc_wdata[p]),
			.write_o                   (acc_write[p]),
			.read_o                    (acc_read[p]),
			.selected_o                (acc_sel[p])
		);

		// Old data on a same-cycle read of a word the other port writes
		always_comb
		begin
			ft_valid_nxt   = acc_read[p]; // RULE7
			ft_data_nxt    = acc_read[p] ? mem[acc_addr[p]] : ft_data_r;
			pipe_valid_nxt = ft_valid_r; // RULE16
			pipe_data_nxt  = ft_data_r;
		end

		always_ff @(posedge clk_i or negedge reset_n_i) // RULE3
		begin
			if (!reset_n_i)
			begin
				ft_data_r    <= dpr_pkg::DATA_RESET_VALUE;
				ft_valid_r   <= 1'b0;
				pipe_data_r  <= dpr_pkg::DATA_RESET_VALUE;
				pipe_valid_r <= 1'b0;
			end
			else
			begin
				ft_data_r    <= ft_data_nxt;
				ft_valid_r   <= ft_valid_nxt;
				pipe_data_r  <= pipe_data_nxt;
				pipe_valid_r <= pipe_valid_nxt;
			end
		end

		// Mode pin is meant to be static; toggling it mid-read may drop a byte
		assign stage_valid = (pin_mode[p] == dpr_pkg::MODE_PIPELINED) ?
			pipe_valid_r : ft_valid_r; // RULE15 RULE16
		assign out_data[p] = (pin_mode[p] == dpr_pkg::MODE_PIPELINED) ?
			pipe_data_r : ft_data_r; // RULE15
		// Output enable works without the clock
		assign out_oe_n[p]    = pin_oe_n[p] || !stage_valid; // RULE8 RULE4
		assign out_standby[p] = !acc_sel[p]; // RULE4 RULE5
	end

endmodule

`default_nettype wire

// File: hw/dpr_pkg.sv
/*
 Constants shared by the dual-port synchronous memory and its port control.
 Assumes nothing of its surroundings; every design file refers to it by name.
*/
`default_nettype none

package dpr_pkg;

	localparam int unsigned ADDR_W    = 17;
	localparam int unsigned DATA_W    = 8;
	localparam int unsigned DEPTH     = 131072;
	localparam int unsigned NUM_PORTS = 2;

	// Port indices inside the per-port arrays
	localparam int unsigned PORT_LEFT  = 0;
	localparam int unsigned PORT_RIGHT = 1;

	// Address counter and register reset values
	localparam logic [16:0] COUNTER_CLEAR_VALUE = 17'h00000;
	localparam logic [16:0] COUNTER_STEP        = 17'h00001;
	localparam logic [16:0] ADDR_RESET_VALUE    = 17'h00000;
	localparam logic [7:0]  DATA_RESET_VALUE    = 8'h00;

	// Output stage select level that picks the pipelined stage
	localparam logic MODE_PIPELINED = 1'b1;

	// Extra read latency of the pipelined stage, in clock cycles
	localparam int unsigned PIPE_EXTRA_CYCLES = 1;

endpackage

`default_nettype wire

// File: hw/dpr_port_ctl.sv
/*
 Input registers and address counter of one memory port.
 Assumes all inputs come from logic on clk_i; no synchroniser is needed.
*/
`timescale 1ns/100ps
`default_nettype none

module dpr_port_ctl
(
	input  wire logic                       clk_i,
	input  wire logic                       reset_n_i,
	input  wire logic [dpr_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [dpr_pkg::DATA_W-1:0] data_i,
	input  wire logic                       port_select_active_low_i,
	input  wire logic                       port_select_active_high_i,
	input  wire logic                       read_write_i,
	input  wire logic                       address_load_strobe_n_i,
	input  wire logic                       counter_advance_n_i,
	input  wire logic                       counter_clear_n_i,
	output logic      [dpr_pkg::ADDR_W-1:0] access_addr_o,
	output logic      [dpr_pkg::DATA_W-1:0] wdata_o,
	output logic                            write_o,
	output logic                            read_o,
	output logic                            selected_o
);

	logic [dpr_pkg::ADDR_W-1:0] counter_r;
	logic [dpr_pkg::ADDR_W-1:0] counter_nxt;
	logic [dpr_pkg::DATA_W-1:0] wdata_r;
	logic [dpr_pkg::DATA_W-1:0] wdata_nxt;
	logic                       write_r;
	logic                       write_nxt;
	logic                       read_r;
	logic                       read_nxt;
	logic                       selected_r;
	logic                       selected_nxt;
	logic                       sel;

	always_comb
	begin
		sel = !port_select_active_low_i && port_select_active_high_i; // RULE4
		// Counter acts regardless of the chip selects
		if (!counter_clear_n_i)
		begin
			counter_nxt = dpr_pkg::COUNTER_CLEAR_VALUE; // RULE9
		end
		else if (!address_load_strobe_n_i)
		begin
			counter_nxt = addr_i; // RULE10 RULE13
		end
		else if (!counter_advance_n_i)
		begin
			counter_nxt = counter_r + dpr_pkg::COUNTER_STEP; // RULE12 RULE14
		end
		else
		begin
			counter_nxt = counter_r; // RULE11
		end
		// Write does not look at output enable; master keeps R/W high on loads
		write_nxt    = sel && !read_write_i; // RULE6 RULE17
		read_nxt     = sel && read_write_i; // RULE7
		wdata_nxt    = data_i;
		selected_nxt = sel;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) // RULE2 RULE3
	begin
		if (!reset_n_i)
		begin
			counter_r  <= dpr_pkg::ADDR_RESET_VALUE;
			wdata_r    <= dpr_pkg::DATA_RESET_VALUE;
			write_r    <= 1'b0;
			read_r     <= 1'b0;
			selected_r <= 1'b0;
		end
		else
		begin
			counter_r  <= counter_nxt;
			wdata_r    <= wdata_nxt;
			write_r    <= write_nxt;
			read_r     <= read_nxt;
			selected_r <= selected_nxt;
		end
	end

	assign access_addr_o = counter_r;
	assign wdata_o       = wdata_r;
	assign write_o       = write_r;
	assign read_o        = read_r;
	assign selected_o    = selected_r;

endmodule

`default_nettype wire

// File: test/dpr_sram_sva.sv
/*
 Port checker for the dual-port memory, bound to dpr_sram.
 Assumes one clock and inputs held idle during reset.
*/
`timescale 1ns/100ps
`default_nettype none
module dpr_sram_sva
(
	input wire logic       clk_i,
	input wire logic       reset_n_i,
	input wire logic [7:0] left_data_o,
	input wire logic       left_data_oe_n_o,
	input wire logic       left_port_select_active_low_i,
	input wire logic       left_port_select_active_high_i,
	input wire logic       left_read_write_i,
	input wire logic       left_output_enable_n_i,
	input wire logic       left_output_stage_select_i,
	input wire logic       left_standby_o,
	input wire logic       right_data_oe_n_o,
	input wire logic       right_port_select_active_low_i,
	input wire logic       right_port_select_active_high_i,
	input wire logic       right_output_enable_n_i,
	input wire logic       right_standby_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	wire logic l_sel = !left_port_select_active_low_i && left_port_select_active_high_i;
	wire logic r_sel = !right_port_select_active_low_i && right_port_select_active_high_i;
	wire logic l_rd  = l_sel && left_read_write_i;
	sequence s_l_rd(logic m);
		l_rd && !left_output_enable_n_i && left_output_stage_select_i == m;
	endsequence
	a_left_oe_gate: assert property (left_output_enable_n_i |-> left_data_oe_n_o)
		else $error("left pins driven with output enable off");
	a_right_oe_gate: assert property (right_output_enable_n_i |-> right_data_oe_n_o)
		else $error("right pins driven with output enable off");
	a_left_standby: assert property (1 |=> left_standby_o == !$past(l_sel))
		else $error("left standby does not follow selects");
	a_right_standby: assert property (1 |=> right_standby_o == !$past(r_sel))
		else $error("right standby does not follow selects");
	a_left_ft_read: assert property (s_l_rd(1'b0) |-> ##2 !left_data_oe_n_o)
		else $error("flow-through read not driven on time");
	a_left_pipe_read: assert property (s_l_rd(1'b1) |-> ##3 !left_data_oe_n_o)
		else $error("pipelined read not driven on time");
	a_left_pipe_late: assert property (!$past(l_rd) ##0 s_l_rd(1'b1) |-> ##2 left_data_oe_n_o)
		else $error("pipelined read driven a cycle early");
	a_left_no_stray: assert property (!left_data_oe_n_o |-> $past(l_rd, 2) || $past(l_rd, 3))
		else $error("left pins driven without a read");
	a_left_hold: assert property (!left_output_stage_select_i
		&& !$past(left_output_stage_select_i) && !$past(l_rd, 2) |-> $stable(left_data_o))
		else $error("left data changed without a read");
endmodule
bind dpr_sram dpr_sram_sva u_dpr_sram_sva (.*);
`default_nettype wire

// File: test/dpr_master.sv
/*
 Bus master model for one memory port.
 Assumes callers start each step right after a rising clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module dpr_master
(
	input  wire logic   clk_i,
	output logic [16:0] addr_o,
	output logic [7:0]  data_o,
	output logic        sel_lo_o,
	output logic        sel_hi_o,
	output logic        clr_n_o,
	output logic        ads_n_o,
	output logic        adv_n_o,
	output logic        rw_o,
	output logic        oe_n_o,
	output logic        mode_o
);
	initial
	begin
		{sel_lo_o, sel_hi_o, clr_n_o, ads_n_o, adv_n_o, rw_o} = 6'h3f;
		addr_o = 17'h00000;
		data_o = 8'h00;
		oe_n_o = 1'b0;
		mode_o = 1'b0;
	end
	// c = sel_lo, sel_hi, clr_n, ads_n, adv_n, rw; no same-word write collisions
	task automatic step(input logic [5:0] c, input logic [16:0] a, input logic [7:0] d);
	begin
		{sel_lo_o, sel_hi_o, clr_n_o, ads_n_o, adv_n_o, rw_o} <= c;
		// Data lines toggle while rw is high and the address is driven inverted while ads_n is high so stale values cannot pass
		addr_o <= c[2] ? ~a : a;
		data_o <= c[0] ? ~data_o : d;
		@(posedge clk_i);
	end
	endtask
endmodule
`default_nettype wire

// File: test/dpr_sram_tb.sv
/*
 Self-checking bench: table of left-port commands, then both-port,
 output enable, pipelined and reset cases. Assumes the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
`define CK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; \
	$display("wrong value %s exp %h got %h", n, e, s); end end
module dpr_sram_tb;
	typedef struct packed {logic [5:0] c; logic [16:0] a; logic [7:0] d; logic chk;} dpr_row_t;
	localparam dpr_row_t ROWS [7] = '{'{6'h3b, 17'h1ffff, 8'h00, 1'b0},
		'{6'h1e, 17'h00000, 8'h5a, 1'b0}, '{6'h0d, 17'h00000, 8'h00, 1'b0},
		'{6'h1e, 17'h00000, 8'ha5, 1'b0}, '{6'h3e, 17'h00000, 8'hff, 1'b0},
		'{6'h1b, 17'h1ffff, 8'h5a, 1'b1}, '{6'h11, 17'h12345, 8'ha5, 1'b1}};
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	int fails = 0;
	int n_compared = 0;
	wire logic [16:0] left_addr_i, right_addr_i;
	wire logic [7:0]  left_data_i, right_data_i, left_data_o, right_data_o;
	wire logic left_data_oe_n_o, right_data_oe_n_o, left_standby_o, right_standby_o;
	wire logic left_port_select_active_low_i, right_port_select_active_low_i;
	wire logic left_port_select_active_high_i, right_port_select_active_high_i;
	wire logic left_read_write_i, right_read_write_i;
	wire logic left_output_enable_n_i, right_output_enable_n_i;
	wire logic left_address_load_strobe_n_i, right_address_load_strobe_n_i;
	wire logic left_counter_advance_n_i, right_counter_advance_n_i;
	wire logic left_counter_clear_n_i, right_counter_clear_n_i;
	wire logic left_output_stage_select_i, right_output_stage_select_i;
	dpr_sram u_dpr_sram (.*);
	dpr_master u_l (.clk_i, .addr_o(left_addr_i), .data_o(left_data_i),
		.sel_lo_o(left_port_select_active_low_i), .sel_hi_o(left_port_select_active_high_i),
		.clr_n_o(left_counter_clear_n_i), .ads_n_o(left_address_load_strobe_n_i),
		.adv_n_o(left_counter_advance_n_i), .rw_o(left_read_write_i),
		.oe_n_o(left_output_enable_n_i), .mode_o(left_output_stage_select_i));
	dpr_master u_r (.clk_i, .addr_o(right_addr_i), .data_o(right_data_i),
		.sel_lo_o(right_port_select_active_low_i), .sel_hi_o(right_port_select_active_high_i),
		.clr_n_o(right_counter_clear_n_i), .ads_n_o(right_address_load_strobe_n_i),
		.adv_n_o(right_counter_advance_n_i), .rw_o(right_read_write_i),
		.oe_n_o(right_output_enable_n_i), .mode_o(right_output_stage_select_i));
	task automatic complete_run();
	begin
		$display("compared %0d, wrong %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask
	task automatic rst_chk();
	begin
		`CK("standby", 1'b1, left_standby_o)
		`CK("right standby", 1'b1, right_standby_o)
		`CK("oe", 1'b1, left_data_oe_n_o)
		`CK("data", 8'h00, left_data_o)
	end
	endtask
	initial
	begin
		forever #2.5 clk_i = ~clk_i;
	end
	initial
	begin
		repeat (2000) @(posedge clk_i);
		fails++;
		complete_run();
	end
	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_chk();
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		foreach (ROWS[i])
		begin
			u_l.step(ROWS[i].c, ROWS[i].a, ROWS[i].d);
			if (ROWS[i].chk)
			begin
				u_l.step(6'h3f, 17'h00000, 8'h00);
				@(negedge clk_i);
				`CK("left data", ROWS[i].d, left_data_o)
				`CK("left oe", 1'b0, left_data_oe_n_o)
				@(posedge clk_i);
			end
		end
		// Right loads word 1 while left reads word 0, then writes word 1 a step later
		fork u_r.step(6'h3b, 17'h00001, 8'h00); u_l.step(6'h11, 17'h12345, 8'h00); join
		fork u_r.step(6'h1e, 17'h00000, 8'h3c); u_l.step(6'h3f, 17'h00000, 8'h00); join
		@(negedge clk_i);
		`CK("left zero", 8'ha5, left_data_o)
		@(posedge clk_i);
		fork u_r.step(6'h1b, 17'h1ffff, 8'h00); u_l.step(6'h1d, 17'h00000, 8'h00); join
		fork u_r.step(6'h3f, 17'h00000, 8'h00); u_l.step(6'h3f, 17'h00000, 8'h00); join
		@(negedge clk_i);
		`CK("left word1", 8'h3c, left_data_o)
		`CK("right top", 8'h5a, right_data_o)
		`CK("right top oe", 1'b0, right_data_oe_n_o)
		@(posedge clk_i);
		// Write and read of word 1 with outputs disabled
		u_l.oe_n_o <= 1'b1;
		u_r.oe_n_o <= 1'b1;
		u_l.step(6'h1e, 17'h00000, 8'hc3);
		// Right reads the top word with its pins disabled across a full cycle
		fork u_r.step(6'h1f, 17'h00000, 8'h00); u_l.step(6'h1f, 17'h00000, 8'h00); join
		fork u_r.step(6'h3f, 17'h00000, 8'h00); u_l.step(6'h3f, 17'h00000, 8'h00); join
		@(negedge clk_i);
		`CK("oe off", 1'b1, left_data_oe_n_o)
		`CK("right oe off", 1'b1, right_data_oe_n_o)
		u_l.oe_n_o = 1'b0;
		#1 `CK("oe on", 1'b0, left_data_oe_n_o)
		`CK("write no oe", 8'hc3, left_data_o)
		@(posedge clk_i);
		u_r.oe_n_o <= 1'b0;
		u_l.mode_o <= 1'b1;
		// Left pipelined while right stays flow-through
		fork u_r.step(6'h1b, 17'h00001, 8'h00); u_l.step(6'h1b, 17'h1ffff, 8'h00); join
		fork u_r.step(6'h3f, 17'h00000, 8'h00); u_l.step(6'h3f, 17'h00000, 8'h00); join
		@(negedge clk_i);
		`CK("pipe early", 1'b1, left_data_oe_n_o)
		`CK("right ft data", 8'hc3, right_data_o)
		`CK("right ft oe", 1'b0, right_data_oe_n_o)
		@(negedge clk_i);
		`CK("pipe oe", 1'b0, left_data_oe_n_o)
		`CK("pipe data", 8'h5a, left_data_o)
		@(posedge clk_i);
		reset_n_i <= 1'b0;
		@(negedge clk_i);
		rst_chk();
		complete_run();
	end
endmodule
`default_nettype wire
